// ---- verilog/clk_halt_pkg.sv ----
// Constants and types for the clock and halt wake-up controller
`default_nettype none
package clk_halt_pkg;
   localparam logic [7:0] ADDR_MAIN_CLK     = 8'h00;
   localparam logic [7:0] ADDR_RC_TRIM      = 8'h01;
   localparam logic [7:0] ADDR_SYS_CTRL     = 8'h02;
   localparam logic [7:0] ADDR_WAKE_CTRL    = 8'h03;
   localparam logic [7:0] ADDR_WAKE_PRESC   = 8'h04;
   localparam logic [7:0] ADDR_HALT_CFG     = 8'h05;
   localparam int         MAIN_OUT_BIT      = 1;
   localparam int         MAIN_SLOW_BIT     = 0;
   localparam int         WAKE_EN_BIT       = 0;
   localparam int         WAKE_MEAS_BIT     = 1;
   localparam int         WAKE_FLAG_BIT     = 2;
   localparam int         CFG_ACTIVE_BIT    = 0;
   localparam logic [7:0] MAIN_CLK_RST      = 8'h00;
   localparam logic [7:0] MAIN_CLK_MASK     = 8'h03;
   localparam logic [7:0] RC_TRIM_RST       = 8'hFF;
   localparam logic [1:0] TRIM_LOW_RST      = 2'h3;
   localparam logic [7:0] WAKE_PRESC_RST    = 8'hFF;
   localparam int         SLOW_DIV          = 32;
   localparam logic [4:0] SLOW_DIV_LAST     = 5'(SLOW_DIV - 1);
   localparam int         WAKE_FIXED_DIV    = 4;
   localparam logic [1:0] WAKE_FIXED_LAST   = 2'(WAKE_FIXED_DIV - 1);
   localparam int         STAB_SHORT_CYC    = 256;
   localparam int         STAB_LONG_CYC     = 4096;
   localparam logic [12:0] STAB_SHORT_LAST  = 13'(STAB_SHORT_CYC - 1);
   localparam logic [12:0] STAB_LONG_LAST   = 13'(STAB_LONG_CYC - 1);
   typedef enum logic [2:0] {st_run, st_halt, st_active, st_wake, st_stab} pwr_state_type;
endpackage
`default_nettype wire

// ---- verilog/div_counter.sv ----
// Wrapping down-free divider counter with terminal pulse
`default_nettype none
module div_counter #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         en,
   input  wire logic         clr,
   input  wire logic [W-1:0] last,
   output logic              tick
);
   logic [W-1:0] cnt_r;
   assign tick = en && (cnt_r == last);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= '0;
      end else if (clr) begin
         cnt_r <= '0;
      end else if (en) begin
         cnt_r <= (cnt_r == last) ? '0 : cnt_r + 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- verilog/clk_halt_ctrl.sv ----
// Main clock, halt entry/exit and timed wake-up controller
// Functional notes
// - Clock output enable 0 leaves pin as I/O; 1 drives clock.
// - Slow mode 0 runs CPU at oscillator; 1 divides by 32.
// - Reset clears main clock register to all zeros.
// - Ten-bit trim code, 000h fastest, 3FFh slowest oscillator.
// - Trim register resets to FFh, lowest frequency.
// - Trim register is upper eight bits; lower two live in system control.
// - Halt instruction enters plain halt when active halt and wake-up disabled.
// - Exit from halt restarts oscillator, waits 256 or 4096 cycles.
// - Halt entry forces interrupt mask to zero unless interrupt entry comes in the same cycle; pending interrupt wakes.
// - In halt, main oscillator and derived clocks stop.
// - Halt with watchdog enabled and halt option gives watchdog reset.
// - Active halt exit delays only on reset, not on interrupt.
// - Active halt exits only on tick, designated interrupts or reset.
// - Interrupt entry sets mask; popping condition codes clears it.
// - Halt with wake-up enabled starts wake-up RC oscillator; main off.
// - Wake-up clock divided by fixed divider, then loaded prescaler.
// - Delay end sets wake-up flag, interrupt, and stabilisation delay.
// - Reading wake-up control register clears flag and interrupt.
// - Measure bit in run routes wake-up clock to timer capture.
`default_nettype none
module clk_halt_ctrl
   import clk_halt_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       ce,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic       halt_exec,
   input  wire logic       irq_halt_wake,
   input  wire logic       irq_tick,
   input  wire logic       irq_enter,
   input  wire logic       cc_pop,
   input  wire logic       wdg_enabled,
   input  wire logic       watchdog_halt_option,
   input  wire logic       stab_long_sel,
   input  wire logic       ext_reset_req,
   input  wire logic       wakeup_rc_clk,
   output logic            osc_run,
   output logic            cpu_clk_en,
   output logic            cpu_reset,
   output logic            clk_out_en,
   output logic            clk_out_pulse,
   output logic            int_mask,
   output logic            wakeup_irq,
   output logic            wakeup_rc_run,
   output logic            capture_src,
   output logic            watchdog_reset,
   output logic      [9:0] rc_trim_code,
   output logic            halted
);
   logic [7:0]    main_clk_r;
   logic [7:0]    rc_trim_r;
   logic [1:0]    trim_low_r;
   logic          wake_en_r;
   logic          wake_meas_r;
   logic          wakeup_flag_r;
   logic [7:0]    wake_presc_r;
   logic          active_halt_r;
   logic          long_sel_r;
   logic          mask_r;
   logic          wdg_rst_r;
   logic          reset_exit_r;
   logic          rc_q_r;
   logic [7:0]    presc_cnt_r;
   logic [12:0]   stab_cnt_r;
   logic          slow_tick;
   logic          fixed_tick;
   logic          rc_edge;
   logic          wake_done;
   logic          halt_req;
   logic          exit_plain;
   logic          exit_active;
   logic          stab_last;
   pwr_state_type state_r;

   assign halt_req    = ce && halt_exec && (state_r == st_run) && !(wdg_enabled && watchdog_halt_option);
   assign exit_plain  = irq_halt_wake || ext_reset_req;
   assign exit_active = irq_tick || irq_halt_wake || ext_reset_req;
   assign rc_edge     = wakeup_rc_clk && !rc_q_r;
   assign wake_done   = fixed_tick && (presc_cnt_r == 8'h00) && (state_r == st_wake);
   assign stab_last   = (stab_cnt_r == (long_sel_r ? STAB_LONG_LAST : STAB_SHORT_LAST));

   // Power state sequencing
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= st_run;
      end else if (ce) begin
         unique case (state_r)
            st_run: begin
               if (halt_req) begin
                  if (wake_en_r) begin
                     state_r <= st_wake;
                  end else if (active_halt_r) begin
                     state_r <= st_active;
                  end else begin
                     state_r <= st_halt;
                  end
               end
            end
            st_halt: begin
               if (exit_plain) begin
                  state_r <= st_stab;
               end
            end
            st_wake: begin
               if (wake_done || exit_plain) begin
                  state_r <= st_stab;
               end
            end
            st_active: begin
               if (ext_reset_req) begin
                  state_r <= st_stab;
               end else if (exit_active) begin
                  state_r <= st_run;
               end
            end
            st_stab: begin
               if (stab_last) begin
                  state_r <= st_run;
               end
            end
         endcase
      end
   end

   // Static delay selection and exit cause
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         long_sel_r   <= 1'b0;
         reset_exit_r <= 1'b0;
      end else if (ce) begin
         if (halt_req) begin
            long_sel_r <= stab_long_sel;
         end
         if (state_r != st_run && state_r != st_stab && ext_reset_req) begin
            reset_exit_r <= 1'b1;
         end else if (state_r == st_stab && stab_last) begin
            reset_exit_r <= 1'b0;
         end
      end
   end

   // Stabilisation delay counter
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stab_cnt_r <= '0;
      end else if (ce) begin
         if (state_r == st_stab && !stab_last) begin
            stab_cnt_r <= stab_cnt_r + 13'h0001;
         end else begin
            stab_cnt_r <= '0;
         end
      end
   end

   // Interrupt mask handling
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mask_r <= 1'b1;
      end else if (ce) begin
         if (irq_enter) begin
            mask_r <= 1'b1;
         end else if (halt_req) begin
            mask_r <= 1'b0;
         end else if (cc_pop) begin
            mask_r <= 1'b0;
         end
      end
   end

   // Watchdog reset instead of halt
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wdg_rst_r <= 1'b0;
      end else if (ce) begin
         wdg_rst_r <= halt_exec && (state_r == st_run) && wdg_enabled && watchdog_halt_option;
      end
   end

   // Register writes
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         main_clk_r    <= MAIN_CLK_RST;
         rc_trim_r     <= RC_TRIM_RST;
         trim_low_r    <= TRIM_LOW_RST;
         wake_en_r     <= 1'b0;
         wake_meas_r   <= 1'b0;
         wake_presc_r  <= WAKE_PRESC_RST;
         active_halt_r <= 1'b0;
      end else if (ce && wr) begin
         unique case (addr)
            ADDR_MAIN_CLK:   main_clk_r <= wdata & MAIN_CLK_MASK;
            ADDR_RC_TRIM:    rc_trim_r <= wdata;
            ADDR_SYS_CTRL:   trim_low_r <= wdata[1:0];
            ADDR_WAKE_CTRL: begin
               wake_en_r   <= wdata[WAKE_EN_BIT];
               wake_meas_r <= wdata[WAKE_MEAS_BIT];
            end
            ADDR_WAKE_PRESC: wake_presc_r <= wdata;
            ADDR_HALT_CFG:   active_halt_r <= wdata[CFG_ACTIVE_BIT];
            default: begin
            end
         endcase
      end
   end

   // Wake-up flag: set wins over read clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wakeup_flag_r <= 1'b0;
      end else if (ce) begin
         if (wake_done) begin
            wakeup_flag_r <= 1'b1;
         end else if (rd && addr == ADDR_WAKE_CTRL) begin
            wakeup_flag_r <= 1'b0;
         end
      end
   end

   // Read data, one cycle after strobe
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= 8'h00;
      end else if (ce) begin
         if (rd) begin
            unique case (addr)
               ADDR_MAIN_CLK:   rdata <= main_clk_r;
               ADDR_RC_TRIM:    rdata <= rc_trim_r;
               ADDR_SYS_CTRL:   rdata <= {6'h00, trim_low_r};
               ADDR_WAKE_CTRL:  rdata <= {5'h00, wakeup_flag_r, wake_meas_r, wake_en_r};
               ADDR_WAKE_PRESC: rdata <= wake_presc_r;
               ADDR_HALT_CFG:   rdata <= {7'h00, active_halt_r};
               default:         rdata <= 8'h00;
            endcase
         end else begin
            rdata <= 8'h00;
         end
      end
   end

   // Wake-up RC edge sampling
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rc_q_r <= 1'b0;
      end else if (ce) begin
         rc_q_r <= wakeup_rc_clk;
      end
   end

   div_counter #(.W(2)) u_fixed_div (
      .clk  (clk),
      .nrst (nrst),
      .en   (ce && rc_edge && state_r == st_wake),
      .clr  (ce && state_r != st_wake),
      .last (WAKE_FIXED_LAST),
      .tick (fixed_tick)
   );

   // Programmable wake-up prescaler
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         presc_cnt_r <= WAKE_PRESC_RST;
      end else if (ce) begin
         if (state_r != st_wake) begin
            presc_cnt_r <= wake_presc_r;
         end else if (fixed_tick && presc_cnt_r != 8'h00) begin
            presc_cnt_r <= presc_cnt_r - 8'h01;
         end
      end
   end

   div_counter #(.W(5)) u_slow_div (
      .clk  (clk),
      .nrst (nrst),
      .en   (ce && osc_run),
      .clr  (1'b0),
      .last (SLOW_DIV_LAST),
      .tick (slow_tick)
   );

   // Clock outputs and status
   assign osc_run        = (state_r == st_run) || (state_r == st_active) || (state_r == st_stab);
   assign cpu_clk_en     = (state_r == st_run) && (main_clk_r[MAIN_SLOW_BIT] ? slow_tick : 1'b1);
   assign clk_out_en     = main_clk_r[MAIN_OUT_BIT];
   assign clk_out_pulse  = main_clk_r[MAIN_OUT_BIT] && cpu_clk_en;
   assign cpu_reset      = reset_exit_r;
   assign int_mask       = mask_r;
   assign wakeup_irq     = wakeup_flag_r;
   assign wakeup_rc_run  = (state_r == st_wake);
   assign capture_src    = wake_meas_r && (state_r == st_run) && wakeup_rc_clk;
   assign watchdog_reset = wdg_rst_r;
   assign rc_trim_code   = {rc_trim_r, trim_low_r};
   assign halted         = (state_r != st_run);

   // Halt entry and wake-up delay end
   sequence halt_entry_s;
      halt_req && !irq_enter;
   endsequence
   sequence wake_end_s;
      ce && wake_done;
   endsequence

   stab_len_a: assert property (@(posedge clk) disable iff (!nrst)
      (ce && state_r == st_stab && stab_cnt_r == 13'h0000 && !long_sel_r) |-> ##256 (state_r == st_run))
      else $error("short stabilisation length wrong");
   stab_bound_a: assert property (@(posedge clk) disable iff (!nrst)
      state_r == st_stab |-> stab_cnt_r <= (long_sel_r ? STAB_LONG_LAST : STAB_SHORT_LAST))
      else $error("stabilisation counter overrun");
   mask_clear_a: assert property (@(posedge clk) disable iff (!nrst)
      halt_entry_s |=> !mask_r)
      else $error("mask not cleared on halt");
   osc_off_a: assert property (@(posedge clk) disable iff (!nrst)
      (state_r == st_halt || state_r == st_wake) |-> !osc_run && !cpu_clk_en)
      else $error("oscillator running in halt");
   wdg_rst_a: assert property (@(posedge clk) disable iff (!nrst)
      (ce && halt_exec && state_r == st_run && wdg_enabled && watchdog_halt_option) |=> watchdog_reset && state_r == st_run)
      else $error("watchdog halt not reset");
   active_exit_a: assert property (@(posedge clk) disable iff (!nrst)
      (ce && state_r == st_active && irq_tick && !ext_reset_req) |=> state_r == st_run)
      else $error("active halt exit wrong");
   reset_exit_a: assert property (@(posedge clk) disable iff (!nrst)
      (ce && state_r == st_active && ext_reset_req) |=> state_r == st_stab && cpu_reset)
      else $error("reset exit not delayed");
   active_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      (ce && state_r == st_active && !irq_tick && !irq_halt_wake && !ext_reset_req) |=> state_r == st_active)
      else $error("active halt left without cause");
   flag_read_a: assert property (@(posedge clk) disable iff (!nrst)
      (ce && rd && addr == ADDR_WAKE_CTRL && !wake_done) |=> !wakeup_irq)
      else $error("wake flag not cleared by read");
   flag_set_a: assert property (@(posedge clk) disable iff (!nrst)
      wake_end_s |=> wakeup_flag_r && state_r == st_stab)
      else $error("wake flag not set");
   main_rsv_a: assert property (@(posedge clk) disable iff (!nrst)
      main_clk_r[7:2] == 6'h00)
      else $error("reserved bits set");
   slow_rate_a: assert property (@(posedge clk) disable iff (!nrst)
      (ce && cpu_clk_en && main_clk_r[MAIN_SLOW_BIT] && !(wr && addr == ADDR_MAIN_CLK)) |=> !cpu_clk_en)
      else $error("slow mode not divided");
endmodule
`default_nettype wire

// ---- testbench/core_model.sv ----
// Processor core model issuing halt and servicing wake interrupts
`default_nettype none
module core_model (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic go_halt,
   input  wire logic halted,
   input  wire logic cpu_reset,
   output logic      halt_exec,
   output logic      irq_enter,
   output logic      cc_pop
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       halted_r;
   logic       reset_r;
   logic [2:0] isr_r;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         halt_exec <= 1'h0;
         irq_enter <= 1'h0;
         cc_pop    <= 1'h0;
         halted_r  <= 1'h0;
         reset_r   <= 1'h0;
         isr_r     <= 3'h0;
      end else begin
         halt_exec <= go_halt;
         halted_r  <= halted;
         reset_r   <= cpu_reset;
         // Interrupt entry only after an interrupt exit, never after a reset exit
         irq_enter <= halted_r & ~halted & ~reset_r;
         isr_r     <= {isr_r[1:0], irq_enter};
         cc_pop    <= isr_r[2];
      end
   end
endmodule
`default_nettype wire

// ---- testbench/tb_clk_halt_ctrl.sv ----
// Self-checking bench for the clock and halt wake-up controller
`default_nettype none
module tb_clk_halt_ctrl;
   import clk_halt_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk, nrst, wr, rd, go_halt, halt_exec, irq_enter, cc_pop, wdg_en, wdg_opt, long_sel;
   logic       rc_clk, rc_on, osc_run, cpu_clk_en, cpu_reset, clk_out_en, clk_out_pulse, int_mask;
   logic       wakeup_irq, wakeup_rc_run, capture_src, watchdog_reset, halted, rs, ce;
   logic [2:0] src;
   logic [7:0] addr, wdata, rdata;
   logic [9:0] rc_trim_code;
   int         n_errors, checks_done, cycles, n_rise, rc_div, n, m, r0;

   clk_halt_ctrl u_dut (.clk(clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .halt_exec(halt_exec), .irq_halt_wake(src[0]), .irq_tick(src[1]), .irq_enter(irq_enter),
      .cc_pop(cc_pop), .wdg_enabled(wdg_en), .watchdog_halt_option(wdg_opt), .stab_long_sel(long_sel),
      .ext_reset_req(src[2]), .wakeup_rc_clk(rc_clk), .osc_run(osc_run), .cpu_clk_en(cpu_clk_en),
      .cpu_reset(cpu_reset), .clk_out_en(clk_out_en), .clk_out_pulse(clk_out_pulse), .int_mask(int_mask),
      .wakeup_irq(wakeup_irq), .wakeup_rc_run(wakeup_rc_run), .capture_src(capture_src),
      .watchdog_reset(watchdog_reset), .rc_trim_code(rc_trim_code), .halted(halted));
   core_model u_core (.clk(clk), .nrst(nrst), .go_halt(go_halt), .halted(halted), .cpu_reset(cpu_reset),
      .halt_exec(halt_exec), .irq_enter(irq_enter), .cc_pop(cc_pop));

   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   // Wake-up RC clock, one eighth of the main rate while enabled
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (rc_on) begin
         rc_div <= rc_div + 1;
         if (rc_div % 4 == 3) begin
            rc_clk <= ~rc_clk;
            if (!rc_clk) n_rise <= n_rise + 1;
         end
      end
      if (cycles == 20000) begin
         n_errors++;
         $display("wrong value at %0t: run timed out", $time);
         summarize();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1;
      chk(rdata, exp, "read data");
   endtask
   task automatic do_halt();
      @(posedge clk);
      go_halt <= 1'h1;
      @(posedge clk);
      go_halt <= 1'h0;
      @(posedge clk);
      #1;
   endtask
   task automatic pulse(input logic [2:0] v);
      @(posedge clk);
      src <= v;
      @(posedge clk);
      src <= 3'h0;
   endtask
   task automatic count_stab(output int k, output logic seen);
      k    = 0;
      seen = 1'h0;
      for (int i = 0; i < 6000; i++) begin
         #1;
         if (halted !== 1'h1) break;
         if (osc_run === 1'h1) k++;
         seen |= cpu_reset;
         @(posedge clk);
      end
   endtask
   task automatic count_en(output int k, output int p);
      k = 0;
      p = 0;
      repeat (64) begin
         @(posedge clk);
         #1;
         if (cpu_clk_en === 1'h1) k++;
         if (clk_out_pulse === 1'h1) p++;
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      {n_errors, checks_done, cycles, n_rise, rc_div} = '0;
      {nrst, wr, rd, go_halt, wdg_en, wdg_opt, long_sel, rc_clk, rc_on, src} = '0;
      ce    = 1'h1;
      addr  = 8'h00;
      wdata = 8'h00;
      repeat (10) @(posedge clk);
      nrst <= 1'h1;
      #1;
      chk({osc_run, cpu_clk_en, halted, int_mask}, 4'hD, "reset outputs");
      rd_reg(ADDR_MAIN_CLK, MAIN_CLK_RST);
      rd_reg(ADDR_RC_TRIM, RC_TRIM_RST);
      chk(rc_trim_code, 10'h3FF, "trim code");
      rd_reg(8'h07, 8'h00);
      $display("test reset done");
      wr_reg(ADDR_MAIN_CLK, 8'h03);
      rd_reg(ADDR_MAIN_CLK, 8'h03);
      chk(clk_out_en, 1'h1, "clock out enable");
      count_en(n, m);
      chk(16'(n), 16'(64 / SLOW_DIV), "slow enables");
      chk(16'(m), 16'(64 / SLOW_DIV), "pin pulses");
      wr_reg(ADDR_MAIN_CLK, 8'h00);
      count_en(n, m);
      chk(16'(n), 16'h0040, "normal enables");
      chk(16'(m), 16'h0000, "pin idle");
      $display("test clock done");
      wr_reg(ADDR_RC_TRIM, 8'h80);
      wr_reg(ADDR_SYS_CTRL, 8'h01);
      rd_reg(ADDR_RC_TRIM, 8'h80);
      chk(rc_trim_code, {8'h80, 2'h1}, "trim code");
      $display("test trim done");
      do_halt();
      chk({halted, osc_run, cpu_clk_en, int_mask}, 4'h8, "plain halt");
      pulse(3'h1);
      count_stab(n, rs);
      chk(16'(n), 16'(STAB_SHORT_CYC), "short delay");
      repeat (3) @(posedge clk);
      #1;
      chk(int_mask, 1'h1, "mask in handler");
      repeat (4) @(posedge clk);
      #1;
      chk(int_mask, 1'h0, "mask after pop");
      $display("test plain halt done");
      wdg_en  <= 1'h1;
      wdg_opt <= 1'h1;
      do_halt();
      chk({watchdog_reset, halted}, 2'h2, "watchdog halt");
      wdg_en  <= 1'h0;
      wdg_opt <= 1'h0;
      $display("test watchdog done");
      wr_reg(ADDR_HALT_CFG, 8'h01);
      long_sel <= 1'h1;
      do_halt();
      pulse(3'h4);
      count_stab(n, rs);
      chk(16'(n), 16'(STAB_LONG_CYC), "long delay");
      chk(rs, 1'h1, "reset exit");
      long_sel <= 1'h0;
      do_halt();
      pulse(3'h2);
      count_stab(n, rs);
      chk(16'(n), 16'h0000, "tick exit");
      repeat (8) @(posedge clk);
      wr_reg(ADDR_HALT_CFG, 8'h00);
      $display("test active halt done");
      wr_reg(ADDR_WAKE_PRESC, 8'h02);
      wr_reg(ADDR_WAKE_CTRL, 8'h01);
      rc_on <= 1'h1;
      do_halt();
      r0 = n_rise;
      chk({halted, osc_run, wakeup_rc_run}, 3'h5, "wake halt");
      for (int i = 0; i < 2000 && osc_run !== 1'h1; i++) begin
         @(posedge clk);
         #1;
      end
      chk(wakeup_irq, 1'h1, "wake flag");
      chk(n_rise - r0 >= 4 * 2 && n_rise - r0 <= 4 * 4, 1'h1, "wake delay");
      count_stab(n, rs);
      chk(16'(n), 16'(STAB_SHORT_CYC), "wake delay end");
      rd_reg(ADDR_WAKE_CTRL, 8'h05);
      rd_reg(ADDR_WAKE_CTRL, 8'h01);
      chk(wakeup_irq, 1'h0, "wake irq cleared");
      $display("test wake halt done");
      wr_reg(ADDR_WAKE_CTRL, 8'h02);
      repeat (10) begin
         @(posedge clk);
         #1;
         chk(capture_src, rc_clk, "capture route");
      end
      rc_on <= 1'h0;
      wr_reg(ADDR_WAKE_CTRL, 8'h00);
      $display("test measure done");
      ce <= 1'h0;
      wr_reg(ADDR_MAIN_CLK, 8'h02);
      ce <= 1'h1;
      rd_reg(ADDR_MAIN_CLK, 8'h00);
      $display("test clock enable done");
      summarize();
   end
endmodule
`default_nettype wire
